/* File: src/serial_link_test_pattern_gen.sv */
`timescale 1ns/1ps
// Function
// - with the transport sample test bit set the sample path carries the raw converter samples.
// - a 4-bit select field in the interface test control picks the pattern, 0000 meaning off and default.
// - a 2-bit point field places the pattern at samples (00), 10-bit symbols (01) or octets (10).
// - at sample injection every sample of a frame gets one value and the pattern steps once per frame.
// - select 0011 gives the 31-bit sequence x^31+x^28+1 seeded 0x0003AFFF.
// - select 0100 gives the 23-bit sequence x^23+x^18+1 seeded 0x003AFF.
// - selects 0101, 0110, 0111 give the 15-, 9- and 7-bit sequences with their listed seeds.
// - select 1000 gives a ramp stepping by one per word, wrapping at the word width of the point.
// - select 1110 repeats user words one to four forever.
// - select 1111 sends user words one to four once and then zeros.
// - the four 16-bit user words come from the registers at 0x0551 to 0x0558.
// - at sample injection each user word goes out with all 16 bits, one word per frame.
// - at symbol injection the pattern steps per symbol, using user bits 15:6 and 10-bit constants.
// - at octet injection the pattern steps per octet, using user bits 15:9 and 8-bit constants.
module serial_link_test_pattern_gen import tpg_pkg::*; (
   input  wire logic         mclk,
   input  wire logic         reset,
   input  wire reg_req_t     reg_req,
   output logic       [7:0]  reg_rdata,
   input  wire sample_beat_t sample_in,
   input  wire symbol_beat_t symbol_in,
   input  wire octet_beat_t  octet_in,
   output sample_beat_t      sample_out,
   output symbol_beat_t      symbol_out,
   output octet_beat_t       octet_out
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic [7:0]    user_byte_reg [USER_BYTES];
   logic [15:0]   user_word [USER_WORDS];
   logic [7:0]    ts_ctrl_reg;
   logic [7:0]    if_ctrl_reg;
   logic [5:0]    cfg_prev_reg;
   logic          soft_reset_reg;
   logic [7:0]    rdata_reg;
   logic [7:0]    rdata_next;
   logic          clr;
   pattern_sel_t  sel;
   inject_point_t point;
   logic          ts_test;
   logic          test_on;
   logic          pattern_active;
   logic          restart;
   logic          advance;
   logic [4:0]    step_bits;
   logic          phase_reg;
   logic [15:0]   ramp_reg;
   logic [1:0]    user_idx_reg;
   user_state_t   user_state_reg;
   logic [15:0]   user_word_sel;
   logic [15:0]   pn_bits [PN_COUNT];
   logic [15:0]   pattern;
   sample_beat_t  sample_reg;
   symbol_beat_t  symbol_reg;
   octet_beat_t   octet_reg;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // word width of an injection point
   function automatic logic [4:0] width_of(input inject_point_t p);
      case (p)
         POINT_SAMPLE: width_of = SAMPLE_BITS;
         POINT_SYMBOL: width_of = SYMBOL_BITS;
         POINT_OCTET:  width_of = OCTET_BITS;
         default:      width_of = SAMPLE_BITS;
      endcase
   endfunction : width_of

   // right-align the top bits of a 16-bit word
   function automatic logic [15:0] take_top(input logic [15:0] w, input logic [3:0] sh);
      take_top = w >> sh;
   endfunction : take_top

   ////////////////////////////////////////////////////////////////////////////
   // register file

   assign clr     = reset | soft_reset_reg;
   assign sel     = pattern_sel_t'(if_ctrl_reg[SEL_MSB:SEL_LSB]);
   assign point   = inject_point_t'(if_ctrl_reg[POINT_MSB:POINT_LSB]);
   assign ts_test = ts_ctrl_reg[TS_TEST_BIT];

   // soft reset strobe, clears itself the next cycle
   always_ff @(posedge mclk) begin
      if (reset) begin
         soft_reset_reg <= 1'b0;
      end else begin
         soft_reset_reg <= reg_req.wr && reg_req.addr == ADDR_SOFT_RESET
                           && reg_req.wdata == SOFT_RESET_CODE;
      end
   end

   // control registers, defaults after either reset
   always_ff @(posedge mclk) begin
      if (clr) begin
         ts_ctrl_reg <= CTRL_RESET;
         if_ctrl_reg <= CTRL_RESET;
      end else if (reg_req.wr) begin
         if (reg_req.addr == ADDR_TS_CTRL) begin
            ts_ctrl_reg <= reg_req.wdata;
         end
         if (reg_req.addr == ADDR_IF_CTRL) begin
            if_ctrl_reg <= reg_req.wdata;
         end
      end
   end

   // user pattern bytes, low byte at the lower address
   generate
      for (genvar b = 0; b < USER_BYTES; b++) begin : g_user
         always_ff @(posedge mclk) begin
            if (clr) begin
               user_byte_reg[b] <= CTRL_RESET;
            end else if (reg_req.wr && reg_req.addr == ADDR_USER_FIRST + 16'(b)) begin
               user_byte_reg[b] <= reg_req.wdata;
            end
         end
      end
      for (genvar w = 0; w < USER_WORDS; w++) begin : g_word
         assign user_word[w] = {user_byte_reg[2*w+1], user_byte_reg[2*w]};
      end
   endgenerate

   // read decode, unmapped addresses read zero
   always_comb begin
      rdata_next = 8'h00;
      if (reg_req.addr >= ADDR_USER_FIRST && reg_req.addr <= ADDR_USER_LAST) begin
         rdata_next = user_byte_reg[3'(reg_req.addr - ADDR_USER_FIRST)];
      end else if (reg_req.addr == ADDR_TS_CTRL) begin
         rdata_next = ts_ctrl_reg;
      end else if (reg_req.addr == ADDR_IF_CTRL) begin
         rdata_next = if_ctrl_reg;
      end else if (reg_req.addr == ADDR_STATUS) begin
         rdata_next = {3'h0, user_state_reg == USER_DONE, user_idx_reg, phase_reg, test_on};
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (reset) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= reg_req.rd ? rdata_next : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencing

   assign test_on = sel != SEL_OFF;

   // only defined codes count as a pattern; others leave data alone
   always_comb begin
      case (sel)
         SEL_CHECKER, SEL_TOGGLE, SEL_PN31, SEL_PRBS_TWENTYTHREE_BIT, SEL_PN15, SEL_PN9, SEL_PN7,
         SEL_RAMP, SEL_USER_REPEAT, SEL_USER_SINGLE: pattern_active = 1'b1;
         default:                                   pattern_active = 1'b0;
      endcase
   end

   // any change of select or point starts the pattern over
   always_ff @(posedge mclk) begin
      if (clr) begin
         cfg_prev_reg <= 6'h00;
      end else begin
         cfg_prev_reg <= if_ctrl_reg[POINT_MSB:SEL_LSB];
      end
   end
   assign restart = !pattern_active || (if_ctrl_reg[POINT_MSB:SEL_LSB] != cfg_prev_reg);

   // one step per frame, symbol or octet
   always_comb begin
      case (point)
         POINT_SAMPLE: advance = sample_in.valid && sample_in.frame_end && !ts_test;
         POINT_SYMBOL: advance = symbol_in.valid;
         POINT_OCTET:  advance = octet_in.valid;
         default:      advance = 1'b0;
      endcase
   end
   assign step_bits = width_of(point);

   // alternation phase for checkerboard and toggle
   always_ff @(posedge mclk) begin
      if (clr || restart) begin
         phase_reg <= 1'b0;
      end else if (advance) begin
         phase_reg <= !phase_reg;
      end
   end

   // ramp; low bits wrap at the point's word width
   always_ff @(posedge mclk) begin
      if (clr || restart) begin
         ramp_reg <= 16'h0000;
      end else if (advance) begin
         ramp_reg <= ramp_reg + 16'h0001;
      end
   end

   // user word index and single-shot state
   always_ff @(posedge mclk) begin
      if (clr || restart) begin
         user_idx_reg   <= 2'h0;
         user_state_reg <= USER_RUN;
      end else if (advance) begin
         user_idx_reg <= user_idx_reg + 2'h1;
         case (user_state_reg)
            USER_RUN: begin
               if (sel == SEL_USER_SINGLE && user_idx_reg == 2'h3) begin
                  user_state_reg <= USER_DONE;
               end
            end
            USER_DONE: user_state_reg <= USER_DONE;
            default:   user_state_reg <= USER_RUN;
         endcase
      end
   end

   // pseudo-random sources, all stepped alike
   generate
      for (genvar g = 0; g < PN_COUNT; g++) begin : g_pn
         prbs_source #(
            .ORDER (PN_ORDER[g]),
            .TAP   (PN_TAP[g]),
            .SEED  (PN_SEED[g])
         ) u_pn (
            .mclk      (mclk),
            .reset     (clr),
            .restart   (restart),
            .advance   (advance),
            .step_bits (step_bits),
            .bits_out  (pn_bits[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // pattern word, right-aligned to the point's width
   assign user_word_sel = user_word[user_idx_reg];

   always_comb begin
      logic [3:0] user_sh;
      logic [3:0] pn_sh;
      user_sh = (point == POINT_SYMBOL) ? USER_SHIFT_SYMBOL :
                (point == POINT_OCTET)  ? USER_SHIFT_OCTET : USER_SHIFT_SAMPLE;
      pn_sh   = 4'(SAMPLE_BITS - step_bits);
      case (sel)
         SEL_CHECKER:     pattern = phase_reg ? CHECKER_ODD : CHECKER_EVEN;
         SEL_TOGGLE:      pattern = phase_reg ? TOGGLE_ODD : TOGGLE_EVEN;
         SEL_PN31:        pattern = take_top(pn_bits[0], pn_sh);
         SEL_PRBS_TWENTYTHREE_BIT:        pattern = take_top(pn_bits[1], pn_sh);
         SEL_PN15:        pattern = take_top(pn_bits[2], pn_sh);
         SEL_PN9:         pattern = take_top(pn_bits[3], pn_sh);
         SEL_PN7:         pattern = take_top(pn_bits[4], pn_sh);
         SEL_RAMP:        pattern = ramp_reg;
         SEL_USER_REPEAT: pattern = take_top(user_word_sel, user_sh);
         SEL_USER_SINGLE: pattern = (user_state_reg == USER_DONE) ? 16'h0000
                                    : take_top(user_word_sel, user_sh);
         default:         pattern = 16'h0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // output stages, one cycle of latency on every path

   // sample path; transport test passes raw samples
   always_ff @(posedge mclk) begin
      if (reset) begin
         sample_reg <= '0;
      end else begin
         sample_reg.valid     <= sample_in.valid;
         sample_reg.frame_end <= sample_in.frame_end;
         if (pattern_active && point == POINT_SAMPLE && !ts_test) begin
            sample_reg.data <= pattern;
         end else begin
            sample_reg.data <= sample_in.data;
         end
      end
   end

   // symbol path
   always_ff @(posedge mclk) begin
      if (reset) begin
         symbol_reg <= '0;
      end else begin
         symbol_reg.valid <= symbol_in.valid;
         symbol_reg.data  <= (pattern_active && point == POINT_SYMBOL) ? pattern[9:0]
                                                                       : symbol_in.data;
      end
   end

   // octet path
   always_ff @(posedge mclk) begin
      if (reset) begin
         octet_reg <= '0;
      end else begin
         octet_reg.valid <= octet_in.valid;
         octet_reg.data  <= (pattern_active && point == POINT_OCTET) ? pattern[7:0]
                                                                     : octet_in.data;
      end
   end

   assign reg_rdata  = rdata_reg;
   assign sample_out = sample_reg;
   assign symbol_out = symbol_reg;
   assign octet_out  = octet_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (clr);

   sequence s_last_user_step;
      sel == SEL_USER_REPEAT && !restart && advance && user_idx_reg == 2'h3;
   endsequence

   a_off_passthru: assert property (
      sel == SEL_OFF && sample_in.valid |=> sample_out.data == $past(sample_in.data))
      else $error("sample data altered with patterns off");

   a_ts_raw_samples: assert property (
      ts_test && sample_in.valid |=> sample_out.data == $past(sample_in.data))
      else $error("transport test did not pass raw samples");

   a_sel_off_idle: assert property (
      sel == SEL_OFF |=> ramp_reg == 16'h0000 && user_idx_reg == 2'h0 && !phase_reg)
      else $error("pattern state moved while off");

   a_point_routing: assert property (
      pattern_active && point == POINT_SYMBOL && sample_in.valid
      |=> sample_out.data == $past(sample_in.data))
      else $error("pattern leaked onto sample path");

   a_frame_hold: assert property (
      pattern_active && point == POINT_SAMPLE && !restart && !(sample_in.valid && sample_in.frame_end)
      |=> $stable(ramp_reg) && $stable(phase_reg) && $stable(user_idx_reg))
      else $error("pattern stepped inside a frame");

   a_checker_value: assert property (
      sel == SEL_CHECKER && point == POINT_SAMPLE && !ts_test && sample_in.valid
      |=> sample_out.data == ($past(phase_reg) ? CHECKER_ODD : CHECKER_EVEN))
      else $error("checkerboard value wrong");

   a_ramp_step: assert property (
      sel == SEL_RAMP && !restart && advance |=> ramp_reg == $past(ramp_reg) + 16'h0001)
      else $error("ramp did not step by one");

   a_user_wrap: assert property (
      s_last_user_step |=> user_idx_reg == 2'h0 && user_state_reg == USER_RUN)
      else $error("repeat mode did not wrap to word one");

   a_single_zero: assert property (
      sel == SEL_USER_SINGLE && user_state_reg == USER_DONE && point == POINT_OCTET && octet_in.valid
      |=> octet_out.data == 8'h00)
      else $error("single mode not zero after four words");

   a_user_word_out: assert property (
      sel == SEL_USER_REPEAT && point == POINT_SAMPLE && !ts_test && sample_in.valid
      |=> sample_out.data == $past(user_word_sel))
      else $error("user word not sent whole");

   a_phy_toggle: assert property (
      sel == SEL_TOGGLE && point == POINT_SYMBOL && symbol_in.valid
      |=> symbol_out.data == ($past(phase_reg) ? 10'h3ff : 10'h000))
      else $error("symbol toggle value wrong");

   a_octet_checker: assert property (
      sel == SEL_CHECKER && point == POINT_OCTET && octet_in.valid
      |=> octet_out.data == ($past(phase_reg) ? 8'haa : 8'h55))
      else $error("octet checkerboard value wrong");

endmodule : serial_link_test_pattern_gen

/* File: src/tpg_pkg.sv */
package tpg_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register map
   localparam logic [15:0] ADDR_SOFT_RESET = 16'h0000;
   localparam logic [15:0] ADDR_USER_FIRST = 16'h0551;
   localparam logic [15:0] ADDR_USER_LAST  = 16'h0558;
   localparam logic [15:0] ADDR_TS_CTRL    = 16'h0571;
   localparam logic [15:0] ADDR_IF_CTRL    = 16'h0573;
   localparam logic [15:0] ADDR_STATUS     = 16'h057f;

   localparam logic [7:0]  SOFT_RESET_CODE = 8'h81;
   localparam logic [7:0]  CTRL_RESET      = 8'h00;
   localparam int          TS_TEST_BIT     = 5;
   localparam int          SEL_LSB         = 0;
   localparam int          SEL_MSB         = 3;
   localparam int          POINT_LSB       = 4;
   localparam int          POINT_MSB       = 5;
   localparam int          USER_BYTES      = 8;
   localparam int          USER_WORDS      = 4;

   ////////////////////////////////////////////////////////////////////////////
   // pattern selection and injection point
   typedef enum logic [3:0] {
      SEL_OFF         = 4'b0000,
      SEL_CHECKER     = 4'b0001,
      SEL_TOGGLE      = 4'b0010,
      SEL_PN31        = 4'b0011,
      SEL_PRBS_TWENTYTHREE_BIT        = 4'b0100,
      SEL_PN15        = 4'b0101,
      SEL_PN9         = 4'b0110,
      SEL_PN7         = 4'b0111,
      SEL_RAMP        = 4'b1000,
      SEL_USER_REPEAT = 4'b1110,
      SEL_USER_SINGLE = 4'b1111
   } pattern_sel_t;

   typedef enum logic [1:0] {
      POINT_SAMPLE = 2'b00,
      POINT_SYMBOL = 2'b01,
      POINT_OCTET  = 2'b10
   } inject_point_t;

   typedef enum logic {
      USER_RUN  = 1'b0,
      USER_DONE = 1'b1
   } user_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // pattern constants and word widths
   localparam logic [15:0] CHECKER_EVEN = 16'h5555;
   localparam logic [15:0] CHECKER_ODD  = 16'haaaa;
   localparam logic [15:0] TOGGLE_EVEN  = 16'h0000;
   localparam logic [15:0] TOGGLE_ODD   = 16'hffff;
   localparam logic [4:0]  SAMPLE_BITS  = 5'h10;
   localparam logic [4:0]  SYMBOL_BITS  = 5'h0a;
   localparam logic [4:0]  OCTET_BITS   = 5'h08;
   localparam logic [3:0]  USER_SHIFT_SAMPLE = 4'h0;
   localparam logic [3:0]  USER_SHIFT_SYMBOL = 4'h6;
   localparam logic [3:0]  USER_SHIFT_OCTET  = 4'h9;

   // pseudo-random generators: order, feedback tap, seed
   localparam int          PN_COUNT = 5;
   localparam int          PN_ORDER [PN_COUNT] = '{31, 23, 15, 9, 7};
   localparam int          PN_TAP   [PN_COUNT] = '{28, 18, 14, 5, 6};
   localparam logic [31:0] PN_SEED  [PN_COUNT] = '{32'h0003afff, 32'h00003aff, 32'h000003af,
                                                   32'h00000092, 32'h00000007};

   ////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   typedef struct packed {
      logic        valid;
      logic        frame_end;
      logic [15:0] data;
   } sample_beat_t;

   typedef struct packed {
      logic        valid;
      logic [9:0]  data;
   } symbol_beat_t;

   typedef struct packed {
      logic        valid;
      logic [7:0]  data;
   } octet_beat_t;

endpackage : tpg_pkg

/* File: src/prbs_source.sv */
`timescale 1ns/1ps
module prbs_source import tpg_pkg::*; #(
   parameter int          ORDER = 9,
   parameter int          TAP   = 5,
   parameter logic [31:0] SEED  = 32'h00000092
) (
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic        restart,
   input  wire logic        advance,
   input  wire logic [4:0]  step_bits,
   output logic      [15:0] bits_out
);

   logic [ORDER-1:0] state_reg;
   logic [ORDER-1:0] state_next;

   // next sixteen serial bits, msb first; state moves by step_bits
   always_comb begin
      logic [ORDER-1:0] st;
      logic             nb;
      st         = state_reg;
      nb         = 1'b0;
      state_next = state_reg;
      bits_out   = '0;
      for (int i = 0; i < 16; i++) begin
         nb            = st[ORDER-1] ^ st[TAP-1];
         bits_out[15-i] = nb;
         st            = {st[ORDER-2:0], nb};
         if (5'(i + 1) == step_bits) begin
            state_next = st;
         end
      end
   end

   // seed on restart, step per output word
   always_ff @(posedge mclk) begin
      if (reset || restart) begin
         state_reg <= SEED[ORDER-1:0];
      end else if (advance) begin
         state_reg <= state_next;
      end
   end

   a_seed_load: assert property (@(posedge mclk) disable iff (reset)
      restart |=> state_reg == SEED[ORDER-1:0])
      else $error("generator not seeded after restart");

endmodule : prbs_source

/* File: tb/link_rx_model.sv */
`timescale 1ns/1ps
module link_rx_model import tpg_pkg::*; (
   input  wire logic         mclk,
   input  wire logic         reset,
   input  wire sample_beat_t sample_out,
   input  wire symbol_beat_t symbol_out,
   input  wire octet_beat_t  octet_out,
   output int                beat_count
);
   // receiver takes every valid beat off the three paths, no back-pressure
   always_ff @(posedge mclk) begin
      if (reset) begin
         beat_count <= 0;
      end else begin
         beat_count <= beat_count + int'(sample_out.valid) + int'(symbol_out.valid) + int'(octet_out.valid);
      end
   end
endmodule : link_rx_model

/* File: tb/test_serial_link_test_pattern_gen.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin n_fail++; $display("BAD %s expected %h seen %h", nm, ex, gt); end end
module test_serial_link_test_pattern_gen import tpg_pkg::*; ;
   typedef logic [15:0] word5_t [5];
   typedef struct {logic [7:0] ctrl; int kind; word5_t e;} row_t;
   localparam word5_t NONE = '{default: 16'h0000};
   logic         mclk;
   logic         reset;
   reg_req_t     reg_req;
   logic [7:0]   reg_rdata;
   sample_beat_t sample_in;
   sample_beat_t sample_out;
   symbol_beat_t symbol_in;
   symbol_beat_t symbol_out;
   octet_beat_t  octet_in;
   octet_beat_t  octet_out;
   int           n_fail, check_count, beats, rx_beats, w;
   logic [31:0]  pn_s;
   logic [15:0]  got, ex, m;
   logic [7:0]   v;
   logic [1:0]   pt;
   logic [15:0]  uw [4] = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0};
   // kind 0 listed words, 1 pass-through, 2 pseudo-random
   row_t rows [23] = '{
      '{8'h01, 0, '{16'h5555, 16'haaaa, 16'h5555, 16'haaaa, 16'h5555}}, '{8'h11, 0, '{16'h155, 16'h2aa, 16'h155, 16'h2aa, 16'h155}},
      '{8'h21, 0, '{16'h55, 16'haa, 16'h55, 16'haa, 16'h55}}, '{8'h02, 0, '{16'h0000, 16'hffff, 16'h0000, 16'hffff, 16'h0000}},
      '{8'h22, 0, '{16'h00, 16'hff, 16'h00, 16'hff, 16'h00}}, '{8'h08, 0, '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4}},
      '{8'h18, 0, '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4}}, '{8'h0e, 0, '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0, 16'h1234}},
      '{8'h1e, 0, '{16'h048, 16'h159, 16'h26a, 16'h37b, 16'h048}}, '{8'h2f, 0, '{16'h09, 16'h2b, 16'h4d, 16'h6f, 16'h00}},
      '{8'h0f, 0, '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0, 16'h0000}}, '{8'h00, 1, NONE}, '{8'h10, 1, NONE},
      '{8'h20, 1, NONE}, '{8'h23, 2, NONE}, '{8'h24, 2, NONE}, '{8'h25, 2, NONE}, '{8'h26, 2, NONE}, '{8'h27, 2, NONE},
      '{8'h04, 2, NONE}, '{8'h09, 1, NONE}, '{8'h31, 1, NONE},
      '{8'h12, 0, '{16'h000, 16'h3ff, 16'h000, 16'h3ff, 16'h000}}};

   serial_link_test_pattern_gen dut_u (.mclk(mclk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .sample_in(sample_in), .symbol_in(symbol_in), .octet_in(octet_in), .sample_out(sample_out),
      .symbol_out(symbol_out), .octet_out(octet_out));
   link_rx_model rx_u (.mclk(mclk), .reset(reset), .sample_out(sample_out), .symbol_out(symbol_out),
      .octet_out(octet_out), .beat_count(rx_beats));

   ////////////////////////////////////////////////////////////////////////////
   // bus and beat tasks
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk) reg_req <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk) reg_req.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge mclk) reg_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge mclk) reg_req.rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   // soft reset between modes, then user words, then control
   task automatic cfg(input logic [7:0] c);
      wr(ADDR_SOFT_RESET, SOFT_RESET_CODE);
      repeat (2) @(posedge mclk);
      for (int k = 0; k < USER_WORDS; k++) begin
         wr(ADDR_USER_FIRST + 16'(2 * k), uw[k][7:0]);
         wr(ADDR_USER_FIRST + 16'(2 * k + 1), uw[k][15:8]);
      end
      wr(ADDR_IF_CTRL, c);
   endtask : cfg

   task automatic send(input logic [1:0] p, input logic fe, input logic [15:0] d, output logic [15:0] g);
      @(posedge mclk);
      case (p)
         2'b00: sample_in <= '{1'b1, fe, d};
         2'b01: symbol_in <= '{1'b1, d[9:0]};
         default: octet_in <= '{1'b1, d[7:0]};
      endcase
      @(posedge mclk);
      sample_in.valid <= 1'b0;
      symbol_in.valid <= 1'b0;
      octet_in.valid <= 1'b0;
      beats++;
      #1 g = (p == 2'b00) ? sample_out.data : (p == 2'b01) ? {6'h00, symbol_out.data} : {8'h00, octet_out.data};
   endtask : send

   function automatic logic [15:0] pn_next(input int idx, input int n);
      logic [15:0] r;
      logic        nb;
      r = 16'h0000;
      for (int i = 0; i < n; i++) begin
         nb = pn_s[PN_ORDER[idx] - 1] ^ pn_s[PN_TAP[idx] - 1];
         pn_s = {pn_s[30:0], nb};
         r = {r[14:0], nb};
      end
      return r;
   endfunction : pn_next

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop

   ////////////////////////////////////////////////////////////////////////////
   // clock and watchdog
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      $display("watchdog expired");
      report_and_stop();
   end

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      reset = 1'b1;
      reg_req = '0;
      sample_in = '0;
      symbol_in = '0;
      octet_in = '0;
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      rd(ADDR_IF_CTRL, v);
      `CHK("if_ctrl reset", 8'h00, v)
      rd(ADDR_TS_CTRL, v);
      `CHK("ts_ctrl reset", 8'h00, v)
      $display("reset values done");
      foreach (rows[r]) begin
         cfg(rows[r].ctrl);
         pt = rows[r].ctrl[5:4];
         w = (pt == 2'b00) ? 16 : (pt == 2'b01) ? 10 : 8;
         m = 16'hffff >> (16 - w);
         if (rows[r].kind == 2) pn_s = PN_SEED[int'(rows[r].ctrl[3:0]) - 3];
         for (int k = 0; k < 5; k++) begin
            send(pt, 1'b1, 16'hc3a5 + 16'(k), got);
            if (rows[r].kind == 0) ex = rows[r].e[k];
            else if (rows[r].kind == 1) ex = (16'hc3a5 + 16'(k)) & m;
            else ex = pn_next(int'(rows[r].ctrl[3:0]) - 3, w);
            `CHK("pattern word", ex, got)
         end
         $display("row %0d done", r);
      end
      // readback, user byte order and an unmapped place
      cfg(8'h1e);
      rd(ADDR_IF_CTRL, v);
      `CHK("if_ctrl readback", 8'h1e, v)
      rd(ADDR_STATUS, v);
      `CHK("status word", 8'h01, v)
      send(2'b00, 1'b1, 16'h2468, got);
      `CHK("sample beside symbol", 16'h2468, got)
      rd(ADDR_USER_FIRST, v);
      `CHK("user low byte", 8'h34, v)
      wr(16'h0600, 8'hff);
      rd(16'h0600, v);
      `CHK("unmapped read", 8'h00, v)
      $display("registers done");
      // one value for a whole frame of three samples
      cfg(8'h01);
      for (int k = 0; k < 6; k++) begin
         send(2'b00, k % 3 == 2, 16'h0f0f, got);
         `CHK("frame word", (k < 3) ? CHECKER_EVEN : CHECKER_ODD, got)
         `CHK("frame end", k % 3 == 2, sample_out.frame_end)
      end
      wr(ADDR_TS_CTRL, 8'h20);
      send(2'b00, 1'b1, 16'h1357, got);
      `CHK("sample test raw", 16'h1357, got)
      $display("frames done");
      // octet ramp wraps at 256
      cfg(8'h28);
      for (int k = 0; k < 257; k++) begin
         send(2'b10, 1'b1, 16'h0000, got);
         `CHK("octet ramp", 16'(k % 256), got)
      end
      repeat (2) @(negedge mclk);
      `CHK("receiver beats", beats, rx_beats)
      $display("ramp done");
      // second reset in mid-run clears the control register
      @(posedge mclk) reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      rd(ADDR_IF_CTRL, v);
      `CHK("if_ctrl after reset", 8'h00, v)
      $display("second reset done");
      report_and_stop();
   end
endmodule : test_serial_link_test_pattern_gen
